// >>> cfg_decoder.sv
/*
 Command byte decoder and result word formatter of a multichannel
 converter. Holds a word FIFO leaf and the top decoder.
 Assumes a serial host; pins are asynchronous to i_clk and are
 synchronised with two flops. SCLK edges are found by sampling.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Bits 7:6 = 01 select setup write
// - Setup bits 5:4 choose clock mode
// - Modes 10,11 turn start pin analog
// - Upper clock-select bit resets to one
// - Setup bits 3:2 choose reference mode
// - Differential bits 00/01 expect no data
// - 10 loads unipolar, 11 bipolar next byte
// - Unipolar bit 7 is pair 0/1 downward
// - Bipolar bit 7 is pair 0/1 downward
// - Bits 7:5 = 001 select averaging write
// - Averaging gives 4,8,16,32 or one conversion
// - Repeat scan returns 4,8,12,16 results
// - Serial clock mode disables averaging
// - Bits 7:4 = 0001 select reset command
// - Bit 3 clears FIFO, else full reset
// - Power-up zeros, setup in mode 10
// - Temperature is high minus low minus offset
// - Ten-bit result: four zeros, two sub-bits
// - Twelve-bit temperature after four zeros
// - Sample on SCLK rise, shift on fall
// - Start by pin in 00/01, write otherwise
// - Unipolar straight binary, bipolar two's complement
// - Bit 7 set means conversion write first
// - Unipolar wins when pair set twice
// - Cut write updates received MSBs only

module word_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clear,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_q != (AW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_q];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_q] <= i_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= i_clear ? '0 : wr_q + AW'(push);
      rd_q  <= i_clear ? '0 : rd_q + AW'(pop);
      cnt_q <= i_clear ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module cfg_decoder (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_din,
  output logic                  o_dout,
  input  wire logic             i_convert_start_pin_n,
  input  wire logic             i_result_valid,
  output logic                  o_result_ready,
  input  wire logic [9:0]       i_result,
  input  wire logic             i_result_is_temp,
  input  wire logic [11:0]      i_temp_high_bias,
  input  wire logic [11:0]      i_temp_low_bias,
  output cfg_pkg::setup_t       o_setup,
  output cfg_pkg::pairing_t     o_pairing,
  output logic [7:0]            o_effective_bipolar,
  output logic [7:0]            o_averaging,
  output cfg_pkg::derived_t     o_derived,
  output logic [7:0]            o_conversion_cmd,
  output logic                  o_start_conversion,
  output logic                  o_fifo_cleared,
  output logic                  o_blocks_shutdown
);
  logic [2:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] din_s;
  logic [2:0] cnv_s;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_n;
  logic [7:0] sh_q;
  logic [2:0] bcnt_q;
  logic       byte_done;
  logic [7:0] rx_byte;
  cfg_pkg::rx_state_t st_q;
  logic [7:0] setup_q;
  logic [7:0] uni_q;
  logic [7:0] bip_q;
  logic [7:0] avg_q;
  logic [7:0] conv_q;
  logic       full_reset;
  logic       fifo_clear;
  logic       start_q;
  logic       clear_q;
  logic       shut_q;
  logic [15:0] tx_q;
  logic [15:0] fmt_word;
  logic [11:0] temp_val;
  logic        f_valid;
  logic        f_pop;
  logic [15:0] f_data;
  logic [1:0]  ck_mode;

  // Pin synchronisers; first flop read only by second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_s <= '0;
      cs_s   <= 2'h3;
      din_s  <= '0;
      cnv_s  <= 3'h7;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s   <= {cs_s[0], i_cs_n};
      din_s  <= {din_s[0], i_din};
      cnv_s  <= {cnv_s[1:0], i_convert_start_pin_n};
    end
  end

  assign cs_n      = cs_s[1];
  assign sclk_rise = sclk_s[1] && !sclk_s[2] && !cs_n;
  assign sclk_fall = !sclk_s[1] && sclk_s[2] && !cs_n;
  assign rx_byte   = {sh_q[6:0], din_s[1]};
  assign byte_done = sclk_rise && (bcnt_q == 3'h7);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_q   <= '0;
      bcnt_q <= '0;
    end
    else if (cs_n)
    begin
      sh_q   <= '0;
      bcnt_q <= '0;
    end
    else if (sclk_rise)
    begin
      sh_q   <= rx_byte;
      bcnt_q <= bcnt_q + 3'h1;
    end
  end

  // Reset command decode
  assign full_reset = byte_done && (rx_byte[7:4] == 4'h1)
                      && !rx_byte[cfg_pkg::BIT_RST_FIFO]
                      && (st_q == cfg_pkg::ST_CMD);
  assign fifo_clear = byte_done && (rx_byte[7:4] == 4'h1)
                      && rx_byte[cfg_pkg::BIT_RST_FIFO]
                      && (st_q == cfg_pkg::ST_CMD);

  // Data byte follower state
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_q <= cfg_pkg::ST_CMD;
    else if (cs_n || full_reset)
      st_q <= cfg_pkg::ST_CMD;
    else if (byte_done)
    begin
      case (st_q)
        cfg_pkg::ST_CMD:
          if (!rx_byte[cfg_pkg::BIT_CONV] && rx_byte[cfg_pkg::BIT_SETUP]
              && rx_byte[cfg_pkg::DIF_HI])
            st_q <= rx_byte[cfg_pkg::DIF_LO] ? cfg_pkg::ST_BIP
                                             : cfg_pkg::ST_UNI;
          else
            st_q <= cfg_pkg::ST_CMD;
        default:
          st_q <= cfg_pkg::ST_CMD;
      endcase
    end
  end

  // Cut write: received MSBs replace, low bits kept
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] part,
                                       input logic [2:0] n);
    logic [7:0] m;
    m = 8'hff << (4'h8 - {1'b0, n});
    merge = ((part << (4'h8 - {1'b0, n})) & m) | (old & ~m);
  endfunction

  // Setup register, with partial MSB-first update on early frame end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      setup_q <= cfg_pkg::SETUP_RST;
    else if (full_reset)
      setup_q <= cfg_pkg::SETUP_RST;
    else if (byte_done && st_q == cfg_pkg::ST_CMD
             && rx_byte[7:6] == 2'h1)
      setup_q <= rx_byte;
    else if (cs_n && bcnt_q > 3'h2 && st_q == cfg_pkg::ST_CMD
             && !sh_q[bcnt_q - 3'h1] && sh_q[bcnt_q - 3'h2])
      setup_q <= merge(setup_q, sh_q, bcnt_q);
  end

  // Pairing registers

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      uni_q <= cfg_pkg::ZERO_RST;
      bip_q <= cfg_pkg::ZERO_RST;
    end
    else if (full_reset)
    begin
      uni_q <= cfg_pkg::ZERO_RST;
      bip_q <= cfg_pkg::ZERO_RST;
    end
    else if (byte_done && st_q == cfg_pkg::ST_UNI)
      uni_q <= rx_byte;
    else if (byte_done && st_q == cfg_pkg::ST_BIP)
      bip_q <= rx_byte;
    else if (cs_n && bcnt_q != 3'h0 && st_q == cfg_pkg::ST_UNI)
      uni_q <= merge(uni_q, sh_q, bcnt_q);
    else if (cs_n && bcnt_q != 3'h0 && st_q == cfg_pkg::ST_BIP)
      bip_q <= merge(bip_q, sh_q, bcnt_q);
  end

  // Averaging and conversion registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      avg_q  <= cfg_pkg::ZERO_RST;
      conv_q <= cfg_pkg::ZERO_RST;
    end
    else if (full_reset)
    begin
      avg_q  <= cfg_pkg::ZERO_RST;
      conv_q <= cfg_pkg::ZERO_RST;
    end
    else if (byte_done && st_q == cfg_pkg::ST_CMD)
    begin
      if (rx_byte[cfg_pkg::BIT_CONV])
        conv_q <= rx_byte;
      else if (rx_byte[7:5] == 3'h1)
        avg_q <= rx_byte;
      // Upper nibble zero falls through untouched
    end
  end

  assign ck_mode = setup_q[cfg_pkg::CK_HI:cfg_pkg::CK_LO];

  // Start, clear and shutdown indications
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      start_q <= 1'b0;
      clear_q <= 1'b0;
      shut_q  <= 1'b1;
    end
    else
    begin
      start_q <= 1'b0;
      clear_q <= fifo_clear || full_reset;
      if (ck_mode[1] && byte_done && st_q == cfg_pkg::ST_CMD
          && rx_byte[cfg_pkg::BIT_CONV])
        start_q <= 1'b1;
      else if (!ck_mode[1] && !cnv_s[1] && cnv_s[2])
        start_q <= 1'b1;
      if (full_reset)
        shut_q <= 1'b1;
      else if (start_q)
        shut_q <= 1'b0;
    end
  end

  always_comb
  begin
    o_derived.convert_by_pin       = !ck_mode[1];
    o_derived.highest_input_analog = ck_mode[1];
    o_derived.neg_ref_is_ref =
      (setup_q[3:2] == cfg_pkg::REF_EXT_DIFF);
    if (!avg_q[cfg_pkg::AVG_EN] || ck_mode == cfg_pkg::CK_SERIAL)
      o_derived.conversions_per_result = 6'd1;
    else
      o_derived.conversions_per_result =
        6'd4 << avg_q[cfg_pkg::AVG_HI:cfg_pkg::AVG_LO];
    if (conv_q[2:1] == cfg_pkg::SCAN_REPEAT)
      o_derived.repeat_results =
        5'd4 + 5'd4 * {3'h0, avg_q[1:0]};
    else
      o_derived.repeat_results = 5'd1;
  end

  assign o_setup.clock_mode = ck_mode;
  assign o_setup.ref_mode   = cfg_pkg::ref_mode_t'(setup_q[3:2]);
  assign o_setup.diff_sel   = setup_q[1:0];
  assign o_pairing.unipolar = uni_q;
  assign o_pairing.bipolar  = bip_q;
  assign o_effective_bipolar = bip_q & ~uni_q;
  assign o_averaging        = avg_q;
  assign o_conversion_cmd   = conv_q;
  assign o_start_conversion = start_q;
  assign o_fifo_cleared     = clear_q;
  assign o_blocks_shutdown  = shut_q;

  // Result word formatting
  assign temp_val = i_temp_high_bias - i_temp_low_bias
                    - cfg_pkg::KELVIN_OFS;
  always_comb
  begin
    if (i_result_is_temp)
      fmt_word = {cfg_pkg::LEAD_ZERO, temp_val};
    else
      fmt_word = {cfg_pkg::LEAD_ZERO, i_result,
                  cfg_pkg::SUB_ZERO};
  end

  word_fifo #(
    .W (cfg_pkg::FIFO_W),
    .D (cfg_pkg::FIFO_D)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_clear (clear_q),
    .i_valid (i_result_valid),
    .o_ready (o_result_ready),
    .i_data  (fmt_word),
    .o_valid (f_valid),
    .i_ready (f_pop),
    .o_data  (f_data)
  );

  // Output shifter, loads while deselected, shifts on falling edges
  logic [3:0] tcnt_q;
  assign f_pop = f_valid && sclk_fall && (tcnt_q == 4'hf);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_q   <= '0;
      tcnt_q <= '0;
    end
    else if (cs_n)
    begin
      tx_q   <= f_valid ? f_data : '0;
      tcnt_q <= '0;
    end
    else if (sclk_fall)
    begin
      tcnt_q <= tcnt_q + 4'h1;
      if (tcnt_q == 4'hf)
        tx_q <= f_valid ? f_data : '0;
      else
        tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign o_dout = tx_q[15];
endmodule

// >>> cfg_decoder_asserts.sv
/*
 Checker for the command byte decoder, watching top ports only.
 Assumes one i_clk domain; bound from the bench top file.
*/
`timescale 1ns/1ns
module cfg_decoder_chk (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_convert_start_pin_n,
  input  cfg_pkg::setup_t   o_setup,
  input  cfg_pkg::pairing_t o_pairing,
  input  wire logic [7:0]  o_effective_bipolar,
  input  wire logic [7:0]  o_averaging,
  input  wire logic [7:0]  o_conversion_cmd,
  input  cfg_pkg::derived_t o_derived,
  input  wire logic        o_start_conversion,
  input  wire logic        o_fifo_cleared,
  input  wire logic        o_blocks_shutdown
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Expected conversions per result and repeat scan result count
  logic [5:0] cpr;
  logic [4:0] scans;
  always_comb
  begin
    cpr = 6'h01;
    if (o_setup.clock_mode != 2'h3 && o_averaging[4])
    begin
      case (o_averaging[3:2])
        2'h0: cpr = 6'h04;
        2'h1: cpr = 6'h08;
        2'h2: cpr = 6'h10;
        default: cpr = 6'h20;
      endcase
    end
    scans = 5'h01;
    if (o_conversion_cmd[2:1] == 2'h2)
      scans = 5'h04 + {1'b0, o_averaging[1:0], 2'h0};
  end

  AST_RST_VAL: assert property ($rose(i_rst_n) |->
    o_setup == 6'h20 && o_pairing == 16'h0000 && o_blocks_shutdown)
    else $error("reset values wrong");
  AST_EFF_BIP: assert property (o_effective_bipolar ==
    (o_pairing.bipolar & ~o_pairing.unipolar))
    else $error("unipolar does not win");
  AST_HI_INPUT: assert property (
    o_derived.highest_input_analog == o_setup.clock_mode[1])
    else $error("start pin use wrong");
  AST_PIN_MODE: assert property (
    o_derived.convert_by_pin == !o_setup.clock_mode[1])
    else $error("start source wrong");
  AST_NEG_REF: assert property (
    o_derived.neg_ref_is_ref == (o_setup.ref_mode == 2'h3))
    else $error("negative reference use wrong");
  AST_AVG_COUNT: assert property (
    o_derived.conversions_per_result == cpr)
    else $error("conversion count wrong");
  AST_SCAN_COUNT: assert property (
    o_derived.repeat_results == scans)
    else $error("repeat count wrong");
  AST_PIN_START: assert property ($fell(i_convert_start_pin_n)
    && o_derived.convert_by_pin |-> ##[1:4] o_start_conversion)
    else $error("pin start missing");
  AST_CLR_PULSE: assert property (
    o_fifo_cleared |=> !o_fifo_cleared)
    else $error("clear pulse too long");
  AST_WAKE: assert property (
    o_start_conversion |=> !o_blocks_shutdown)
    else $error("still shut down after start");
  AST_IDLE_HOLD: assert property (i_cs_n [*6] |=>
    $stable(o_setup) && $stable(o_pairing))
    else $error("registers changed while deselected");

  cover property (o_start_conversion);
  cover property (o_fifo_cleared);
  cover property (o_effective_bipolar != 8'h00);
endmodule

// >>> cfg_decoder_test.sv
/*
 Bench for the command byte decoder: frames through the host model.
 Assumes the checker and host model are compiled first.
*/
`timescale 1ns/1ns
module cfg_decoder_test;
  logic              i_clk;
  logic              i_rst_n;
  logic              sclk;
  logic              cs_n;
  logic              din;
  logic              dout;
  logic              pin_n;
  logic              rv;
  logic              rdy;
  logic [9:0]        res;
  cfg_pkg::setup_t   setup;
  cfg_pkg::pairing_t pair;
  cfg_pkg::derived_t der;
  logic [7:0]        effb;
  logic [7:0]        avg;
  logic [7:0]        cmd;
  logic              start;
  logic              clr;
  logic              shut;
  logic              tmp;
  logic [11:0]       hb;
  logic [11:0]       lb;
  logic [15:0]       rx;
  int                st_cnt = 0;
  int                clr_cnt = 0;
  int                n0;
  int                err_count;
  int                checked;

  spi_host host (.i_clk(i_clk), .i_dout(dout), .o_sclk(sclk),
                 .o_cs_n(cs_n), .o_din(din), .o_rx(rx));

  cfg_decoder dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_din(din), .o_dout(dout), .i_convert_start_pin_n(pin_n),
    .i_result_valid(rv), .o_result_ready(rdy), .i_result(res),
    .i_result_is_temp(tmp), .i_temp_high_bias(hb),
    .i_temp_low_bias(lb), .o_setup(setup), .o_pairing(pair),
    .o_effective_bipolar(effb), .o_averaging(avg), .o_derived(der),
    .o_conversion_cmd(cmd), .o_start_conversion(start),
    .o_fifo_cleared(clr), .o_blocks_shutdown(shut));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    if (start === 1'b1) st_cnt <= st_cnt + 1;
    if (clr === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s exp %h got %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(input logic [15:0] tx, input int n);
    host.xfer(tx, n);
    cyc(8);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    err_count++;
    test_done();
  end

  initial
  begin
    i_rst_n = 1'b0;
    pin_n = 1'b1;
    rv = 1'b0;
    res = 10'h155;
    tmp = 1'b0;
    hb = 12'h999;
    lb = 12'h011;
    err_count = 0;
    checked = 0;
    cyc(10);
    i_rst_n = 1'b1;
    cyc(4);
    chk("setup", 16'h0020, setup);
    chk("pairing", 16'h0000, pair);
    chk("shutdown", 16'h0001, shut);
    for (int m = 0; m < 4; m++)
    begin
      wr({10'h001, m[1:0], ~m[1:0], 1'b0, m[0]}, 8);
      chk("setup", {10'h0, m[1:0], ~m[1:0], 1'b0, m[0]}, setup);
      chk("hi_input", {15'h0, m[1]}, der.highest_input_analog);
      chk("pairing", 16'h0000, pair);
    end
    wr(16'h42a5, 16);
    chk("pairing", 16'ha500, pair);
    wr(16'h473c, 16);
    chk("pairing", 16'ha53c, pair);
    chk("eff_bip", 16'h0018, effb);
    wr(16'h0420, 12);
    chk("pairing", 16'h053c, pair);
    wr(16'h000f, 8);
    chk("setup", 16'h0002, setup);
    wr(16'h00c1, 8);
    chk("conv_cmd", 16'h00c1, cmd);
    chk("setup", 16'h0002, setup);
    n0 = st_cnt;
    pin_n = 1'b0;
    cyc(4);
    pin_n = 1'b1;
    cyc(6);
    chk("pin_start", 16'h0001, 16'(st_cnt - n0));
    chk("shutdown", 16'h0000, shut);
    wr(16'h0060, 8);
    n0 = st_cnt;
    pin_n = 1'b0;
    cyc(4);
    pin_n = 1'b1;
    cyc(6);
    chk("pin_start", 16'h0000, 16'(st_cnt - n0));
    wr(16'h0085, 8);
    chk("wr_start", 16'h0001, 16'(st_cnt - n0));
    for (int k = 0; k < 4; k++)
    begin
      wr({8'h00, 4'h3, k[1:0], k[1:0]}, 8);
      chk("avg", {8'h00, 4'h3, k[1:0], k[1:0]}, avg);
      chk("cpr", 16'h0004 << k, der.conversions_per_result);
      chk("scans", 16'h0004 * (k + 1), der.repeat_results);
    end
    wr(16'h0023, 8);
    chk("cpr", 16'h0001, der.conversions_per_result);
    wr(16'h0037, 8);
    wr(16'h0070, 8);
    chk("cpr", 16'h0001, der.conversions_per_result);
    rv = 1'b1; cyc(40); rv = 1'b0;
    chk("fifo_full", 16'h0000, rdy);
    n0 = clr_cnt;
    wr(16'h001f, 8);
    chk("fifo_clr", 16'h0001, 16'(clr_cnt - n0));
    chk("fifo_rdy", 16'h0001, rdy);
    chk("avg", 16'h0037, avg);
    wr(16'h0017, 8);
    chk("setup", 16'h0020, setup);
    chk("pairing", 16'h0000, pair);
    chk("avg", 16'h0000, avg);
    chk("shutdown", 16'h0001, shut);
    rv = 1'b1;
    cyc(1);
    rv = 1'b0;
    wr(16'h0000, 16);
    chk("dout", {4'h0, res, 2'h0}, rx);
    tmp = 1'b1;
    rv = 1'b1;
    cyc(1);
    rv = 1'b0;
    tmp = 1'b0;
    wr(16'h0000, 16);
    chk("temp", {4'h0, 12'(hb - lb - cfg_pkg::KELVIN_OFS)}, rx);
    test_done();
  end
endmodule

bind cfg_decoder cfg_decoder_chk chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
  .i_convert_start_pin_n(i_convert_start_pin_n), .o_setup(o_setup),
  .o_pairing(o_pairing), .o_effective_bipolar(o_effective_bipolar),
  .o_averaging(o_averaging), .o_conversion_cmd(o_conversion_cmd),
  .o_derived(o_derived),
  .o_start_conversion(o_start_conversion),
  .o_fifo_cleared(o_fifo_cleared), .o_blocks_shutdown(o_blocks_shutdown));

// >>> cfg_pkg.sv
/*
 Package for the command byte configuration decoder: opcode patterns,
 field positions, reset values, mode encodings and carrier structs.
 Assumes a single 25 MHz system clock domain.
*/
package cfg_pkg;
  localparam int CLK_HZ          = 25_000_000;
  localparam int SCLK_MAX_HZ     = 4_800_000;
  localparam int FIFO_W          = 16;
  localparam int FIFO_D          = 16;
  localparam int BYTE_W          = 8;
  localparam int BIT_CONV        = 7;
  localparam int BIT_SETUP       = 6;
  localparam int BIT_AVG         = 5;
  localparam int BIT_RST         = 4;
  localparam int BIT_RST_FIFO    = 3;
  localparam int CK_HI           = 5;
  localparam int CK_LO           = 4;
  localparam int REF_HI          = 3;
  localparam int REF_LO          = 2;
  localparam int DIF_HI          = 1;
  localparam int DIF_LO          = 0;
  localparam int AVG_EN          = 4;
  localparam int AVG_HI          = 3;
  localparam int AVG_LO          = 2;
  localparam int SCN_HI          = 1;
  localparam int SCN_LO          = 0;
  localparam logic [7:0] SETUP_RST = 8'h20;
  localparam logic [7:0] ZERO_RST  = 8'h00;
  localparam logic [1:0] CK_INT_AUTO = 2'h0;
  localparam logic [1:0] CK_INT_CNV  = 2'h1;
  localparam logic [1:0] CK_INT_WR   = 2'h2;
  localparam logic [1:0] CK_SERIAL   = 2'h3;
  localparam logic [1:0] DIF_UNI     = 2'h2;
  localparam logic [1:0] DIF_BIP     = 2'h3;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [3:0] LEAD_ZERO   = 4'h0;
  localparam logic [1:0] SUB_ZERO    = 2'h0;
  localparam logic [11:0] KELVIN_OFS = 12'h888;

  typedef enum logic [1:0] {
    REF_INT_AUTO = 2'b00,
    REF_EXT_SE   = 2'b01,
    REF_INT_ON   = 2'b10,
    REF_EXT_DIFF = 2'b11
  } ref_mode_t;

  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_UNI  = 2'b01,
    ST_BIP  = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic [1:0] clock_mode;
    ref_mode_t  ref_mode;
    logic [1:0] diff_sel;
  } setup_t;

  typedef struct packed {
    logic [7:0] unipolar;
    logic [7:0] bipolar;
  } pairing_t;

  typedef struct packed {
    logic       convert_by_pin;
    logic       highest_input_analog;
    logic       neg_ref_is_ref;
    logic [5:0] conversions_per_result;
    logic [4:0] repeat_results;
  } derived_t;
endpackage

// >>> spi_host.sv
/*
 Serial host model: idle-low clock, 320 ns period, MSB first.
 Assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ns
module spi_host (
  input  wire logic   i_clk,
  input  wire logic   i_dout,
  output logic        o_sclk,
  output logic        o_cs_n,
  output logic        o_din,
  output logic [15:0] o_rx
);
  initial
  begin
    o_rx   = 16'h0000;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b1;
  end

  // Half a serial period
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask

  // Frame of n bits; select held for the whole frame
  task automatic xfer(input logic [15:0] tx, input int n);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--)
    begin
      o_din = tx[i];
      half();
      o_sclk = 1'b1;
      o_rx = {o_rx[14:0], i_dout};
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    o_din  = ~o_din;
    half();
  endtask
endmodule
